// File: pls_top.sv
// Purpose: Position limit supervisor with AHB-Lite register slave
// Assumes: Actual position, current and torque inputs are synchronous
// Notes:   Persistent store is outside; zero loads once after reset
`timescale 1ns/1ps
`include "pls_params.svh"

module pls_top
  import pls_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [31:0] pos_act,
  input  wire logic [31:0] cur_act,
  input  wire logic [31:0] trq_act,
  input  wire logic [18:0] nv_zero,
  input  wire logic        nv_zero_valid,
  input  wire logic        nv_done,
  output logic             nv_wr,
  output logic [18:0]      nv_zero_wdata,
  output logic [31:0]      pos_cmd,
  output logic [31:0]      trq_cmd,
  output logic             power_en,
  output logic             brake_engage,
  output logic             quick_stop,
  output logic             prof_decel,
  output logic [18:0]      zero_pos
);

  localparam logic [11:0] SAVE_CYC = 12'(`PLS_SAVE_CYCLES);

  pls_state_t s_r;
  pls_state_t s_nxt;

  logic              addr_ok;
  logic              at_lo;
  logic              at_hi;
  logic              beyond_lo;
  logic              beyond_hi;
  logic              torque_mode;
  logic              trq_inward;
  logic [31:0]       clamped;
  logic [31:0]       rd_mux;
  logic [31:0]       wdata;

  // ************************************************************
  // Limit comparisons
  // ************************************************************
  // Reached or passed each limit, signed
  assign at_lo       = $signed(pos_act) <= $signed(s_r.lim_lo);
  assign at_hi       = $signed(pos_act) >= $signed(s_r.lim_hi);
  // Target outside the permitted range
  assign beyond_lo   = $signed(s_r.tgt_pos) < $signed(s_r.lim_lo);
  assign beyond_hi   = $signed(s_r.tgt_pos) > $signed(s_r.lim_hi);
  assign torque_mode = (s_r.mode == `PLS_MODE_PT) || (s_r.mode == `PLS_MODE_CST);
  // Torque that drives the shaft back toward the range
  assign trq_inward  = (at_lo && $signed(s_r.tgt_trq) > 0)
                    || (at_hi && $signed(s_r.tgt_trq) < 0);

  // Target clamped onto the nearer limit
  always_comb
  begin
    if (beyond_lo)
      clamped = s_r.lim_lo;
    else if (beyond_hi)
      clamped = s_r.lim_hi;
    else
      clamped = s_r.tgt_pos;
  end

  // ************************************************************
  // Register read mux
  // ************************************************************
  assign addr_ok = hsel && htrans[1] && hready;
  assign wdata   = hwdata;

  // Read value for the pending address
  always_comb
  begin
    unique case (s_r.bus.addr)
      `PLS_OFF_MODE:     rd_mux = {24'h000000, s_r.mode};
      `PLS_OFF_ZERO_CAL: rd_mux = {13'h0000, s_r.zero_cal};
      `PLS_OFF_LIM_LO:   rd_mux = s_r.lim_lo;
      `PLS_OFF_LIM_HI:   rd_mux = s_r.lim_hi;
      `PLS_OFF_SAVE:     rd_mux = {30'h00000000, s_r.save_st};
      `PLS_OFF_TGT_POS:  rd_mux = s_r.tgt_pos;
      `PLS_OFF_TGT_TRQ:  rd_mux = s_r.tgt_trq;
      `PLS_OFF_STATUS:   rd_mux = {28'h0000000, s_r.quick_stop, ~s_r.power_en, s_r.viol};
      `PLS_OFF_ZERO_ACT: rd_mux = {13'h0000, s_r.zero_act};
      `PLS_OFF_CUR_RPT:  rd_mux = s_r.cur_rpt;
      `PLS_OFF_TRQ_RPT:  rd_mux = s_r.trq_rpt;
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.nv_wr     = 1'b0;

    // Bus: writes land in data phase, reads take one wait state
    s_nxt.bus.wr_pend = 1'b0;
    s_nxt.bus.hready  = 1'b1;
    if (s_r.bus.rd_pend)
    begin
      s_nxt.bus.hrdata  = rd_mux;
      s_nxt.bus.rd_pend = 1'b0;
    end
    if (s_r.bus.wr_pend)
    begin
      unique case (s_r.bus.addr)
        `PLS_OFF_MODE:
          s_nxt.mode = wdata[7:0];
        `PLS_OFF_ZERO_CAL:
        begin
          if (wdata <= {13'h0000, `PLS_ZERO_MAX})
            s_nxt.zero_cal = wdata[18:0];
        end
        `PLS_OFF_LIM_LO:
          s_nxt.lim_lo = wdata;
        `PLS_OFF_LIM_HI:
          s_nxt.lim_hi = wdata;
        `PLS_OFF_SAVE:
        begin
          if (s_r.save_st != `PLS_SAVE_BUSY)
          begin
            if (wdata == `PLS_SAVE_KEY)
            begin
              s_nxt.save_st  = `PLS_SAVE_BUSY;
              s_nxt.save_cnt = SAVE_CYC;
              s_nxt.nv_wr    = 1'b1;
            end
            else
              s_nxt.save_st = `PLS_SAVE_INVALID;
          end
        end
        `PLS_OFF_TGT_POS:
          s_nxt.tgt_pos = wdata;
        `PLS_OFF_TGT_TRQ:
          s_nxt.tgt_trq = wdata;
        default:
          s_nxt.mode = s_r.mode;
      endcase
    end
    if (addr_ok)
    begin
      s_nxt.bus.addr = haddr[7:0];
      if (hwrite)
        s_nxt.bus.wr_pend = 1'b1;
      else
      begin
        s_nxt.bus.rd_pend = 1'b1;
        s_nxt.bus.hready  = 1'b0;
      end
    end

    // Save runs for a minimum time and until the store confirms
    if (s_r.save_st == `PLS_SAVE_BUSY)
    begin
      if (s_r.save_cnt != 12'h000)
        s_nxt.save_cnt = s_r.save_cnt - 12'h001;
      else if (nv_done)
        s_nxt.save_st = `PLS_SAVE_DONE;
    end

    // Zero is taken from the store only once after restart
    if (!s_r.booted)
    begin
      s_nxt.booted = 1'b1;
      if (nv_zero_valid)
        s_nxt.zero_act = nv_zero;
      else
        s_nxt.zero_act = `PLS_ZERO_DEFAULT;
    end

    // Motion supervision defaults: inside range, all accepted
    s_nxt.viol       = {at_hi, at_lo};
    s_nxt.power_en   = 1'b1;
    s_nxt.quick_stop = 1'b0;
    s_nxt.prof_decel = 1'b0;
    s_nxt.pos_cmd    = s_r.tgt_pos;
    s_nxt.trq_cmd    = s_r.tgt_trq;
    s_nxt.cur_rpt    = cur_act;
    s_nxt.trq_rpt    = trq_act;

    unique case (s_r.mode)
      `PLS_MODE_PP:
      begin
        // Plan toward the limit, stop there at profile deceleration
        s_nxt.pos_cmd    = clamped;
        s_nxt.prof_decel = beyond_lo || beyond_hi;
      end
      `PLS_MODE_CSP:
      begin
        if (at_lo || at_hi)
        begin
          s_nxt.quick_stop = 1'b1;
          // Inside targets run, others hold the hit limit
          if (beyond_lo || beyond_hi)
            s_nxt.pos_cmd = at_lo ? s_r.lim_lo : s_r.lim_hi;
        end
      end
      `PLS_MODE_PT,
      `PLS_MODE_CST:
      begin
        if (at_lo || at_hi)
        begin
          if (trq_inward)
            s_nxt.trq_cmd = s_r.tgt_trq;
          else
          begin
            s_nxt.trq_cmd  = 32'h00000000;
            s_nxt.power_en = 1'b0;
            s_nxt.cur_rpt  = 32'h00000000;
            s_nxt.trq_rpt  = 32'h00000000;
          end
        end
      end
      default:
        s_nxt.pos_cmd = s_r.tgt_pos;
    endcase
    if (!torque_mode)
      s_nxt.trq_cmd = s_r.tgt_trq;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r             <= '0;
      s_r.bus.hready  <= 1'b1;
      s_r.zero_cal    <= `PLS_ZERO_DEFAULT;
      s_r.zero_act    <= `PLS_ZERO_DEFAULT;
      s_r.lim_lo      <= `PLS_LIM_LO_RST;
      s_r.lim_hi      <= `PLS_LIM_HI_RST;
      s_r.save_st     <= `PLS_SAVE_INVALID;
      s_r.power_en    <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Bus answers
  assign hreadyout     = s_r.bus.hready;
  assign hresp         = 1'b0;
  assign hrdata        = s_r.bus.hrdata;
  // Store write strobe and data
  assign nv_wr         = s_r.nv_wr;
  assign nv_zero_wdata = s_r.zero_cal;
  // Drive commands; brake never engages on a limit
  assign pos_cmd       = s_r.pos_cmd;
  assign trq_cmd       = s_r.trq_cmd;
  assign power_en      = s_r.power_en;
  assign brake_engage  = 1'b0;
  assign quick_stop    = s_r.quick_stop;
  assign prof_decel    = s_r.prof_decel;
  assign zero_pos      = s_r.zero_act;

endmodule // pls_top

// File: pls_params.svh
// Purpose: Constants for the position limit supervisor
// Assumes: 25 MHz hclk, AHB-Lite word registers
// Notes:   Offsets are byte addresses
`ifndef PLS_PARAMS_SVH
`define PLS_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PLS_OFF_MODE      8'h00
`define PLS_OFF_ZERO_CAL  8'h04
`define PLS_OFF_LIM_LO    8'h08
`define PLS_OFF_LIM_HI    8'h0C
`define PLS_OFF_SAVE      8'h10
`define PLS_OFF_TGT_POS   8'h14
`define PLS_OFF_TGT_TRQ   8'h18
`define PLS_OFF_STATUS    8'h1C
`define PLS_OFF_ZERO_ACT  8'h20
`define PLS_OFF_CUR_RPT   8'h24
`define PLS_OFF_TRQ_RPT   8'h28

// ************************************************************
// Operating modes
// ************************************************************
`define PLS_MODE_PP       8'h01
`define PLS_MODE_PT       8'h04
`define PLS_MODE_CSP      8'h08
`define PLS_MODE_CST      8'h0A

// ************************************************************
// Values, fields and timing
// ************************************************************
`define PLS_ZERO_MAX      19'h7FFFF
`define PLS_ZERO_DEFAULT  19'h40000
`define PLS_LIM_LO_RST    32'h80000000
`define PLS_LIM_HI_RST    32'h7FFFFFFF
`define PLS_SAVE_KEY      32'h65766173
`define PLS_SAVE_INVALID  2'h0
`define PLS_SAVE_BUSY     2'h1
`define PLS_SAVE_DONE     2'h2
`define PLS_STAT_VIOL_LO  0
`define PLS_STAT_VIOL_HI  1
`define PLS_STAT_CUT      2
`define PLS_STAT_QSTOP    3
`define PLS_CLK_MHZ       25
`define PLS_SAVE_TIME_US  100
`define PLS_SAVE_CYCLES   (`PLS_SAVE_TIME_US * `PLS_CLK_MHZ)

`endif

// File: pls_pkg.sv
// Purpose: Types for the position limit supervisor
// Assumes: Constants come from pls_params.svh
// Notes:   One packed struct holds all state
package pls_pkg;

  // ************************************************************
  // Bus side state
  // ************************************************************
  typedef struct packed {
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr;
    logic        hready;
    logic [31:0] hrdata;
  } pls_bus_t;

  // ************************************************************
  // Whole block state
  // ************************************************************
  typedef struct packed {
    pls_bus_t    bus;
    logic [7:0]  mode;
    logic [18:0] zero_cal;
    logic [18:0] zero_act;
    logic        booted;
    logic [31:0] lim_lo;
    logic [31:0] lim_hi;
    logic [31:0] tgt_pos;
    logic [31:0] tgt_trq;
    logic [1:0]  save_st;
    logic [11:0] save_cnt;
    logic [31:0] pos_cmd;
    logic [31:0] trq_cmd;
    logic        power_en;
    logic        quick_stop;
    logic        prof_decel;
    logic [1:0]  viol;
    logic [31:0] cur_rpt;
    logic [31:0] trq_rpt;
    logic        nv_wr;
  } pls_state_t;

endpackage

// File: pls_store_model.sv
// Purpose: Persistent store model on the save side of the supervisor
// Assumes: Store keeps its content through resets
// Notes:   Finishes a save a few cycles after the write pulse
`timescale 1ns/1ps

module pls_store_model
(
  input  wire logic        hclk,
  input  wire logic        nv_wr,
  input  wire logic [18:0] nv_zero_wdata,
  output logic [18:0]      nv_zero,
  output logic             nv_zero_valid,
  output logic             nv_done
);
  logic [18:0] mem_r;
  logic [3:0]  cnt_r;

  // ****************************************************
  // Store write and completion
  // ****************************************************
  initial
  begin
    mem_r = 19'h00000;
    cnt_r = 4'h0;
    nv_zero_valid = 1'b0;
    nv_done = 1'b0;
  end

  // New zero held until the next power up
  always @(posedge hclk)
  begin
    if (nv_wr)
    begin
      nv_done <= 1'b0;
      cnt_r   <= 4'h8;
      mem_r   <= nv_zero_wdata;
    end
    else if (cnt_r == 4'h1)
    begin
      nv_done       <= 1'b1;
      nv_zero_valid <= 1'b1;
      cnt_r         <= 4'h0;
    end
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end

  // Garbage while nothing valid is stored
  assign nv_zero = nv_zero_valid ? mem_r : ~mem_r;
endmodule // pls_store_model

// File: pls_top_assertions.sv
// Purpose: Concurrent checks on the supervisor ports
// Assumes: One clock domain, async active low reset
// Notes:   Bound into every pls_top instance
`timescale 1ns/1ps
`include "pls_params.svh"

module pls_top_assertions
  import pls_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [18:0] nv_zero,
  input wire logic        nv_zero_valid,
  input wire logic        nv_wr,
  input wire logic [31:0] trq_cmd,
  input wire logic        power_en,
  input wire logic        brake_engage,
  input wire logic        quick_stop,
  input wire logic [18:0] zero_pos
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_r;
  logic wr_r;
  logic boot_r;
  wire  take = hsel & htrans[1] & hready;

  // ****************************************************
  // Helper flags
  // ****************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_r   <= 1'b0;
      wr_r   <= 1'b0;
      boot_r <= 1'b0;
    end
    else
    begin
      rd_r   <= take & ~hwrite;
      wr_r   <= take & hwrite & (haddr[7:0] == `PLS_OFF_SAVE);
      boot_r <= 1'b1;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_brake_never: assert property (!brake_engage) else $error("brake engaged");
  a_cut_no_torque: assert property (!power_en |-> trq_cmd == 32'h0)
    else $error("torque while cut");
  a_save_pulse: assert property (nv_wr |=> !nv_wr) else $error("long save pulse");
  a_save_key: assert property (nv_wr |->
    ($past(wr_r) && $past(hwdata) == `PLS_SAVE_KEY) ||
    ($past(wr_r, 2) && $past(hwdata, 2) == `PLS_SAVE_KEY)) else $error("save without key");
  // Zero loads at the first edge after release, then never moves until the next reset
  a_zero_stable: assert property (boot_r |=> $stable(zero_pos)) else $error("zero moved");
  a_zero_boot: assert property (!boot_r && hresetn |=> zero_pos ==
    ($past(nv_zero_valid) ? $past(nv_zero) : `PLS_ZERO_DEFAULT)) else $error("bad boot zero");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read timing");
  a_write_ready: assert property (take && hwrite |=> hreadyout) else $error("write stall");
  a_stop_powered: assert property (quick_stop |-> power_en) else $error("stop unpowered");

  c_save: cover property (nv_wr);
  c_cut: cover property (!power_en);
  c_stop: cover property (quick_stop);
endmodule // pls_top_assertions

bind pls_top pls_top_assertions u_chk (.*);

// File: pls_top_tb.sv
// Purpose: Self-checking bench for the supervisor
// Assumes: AHB-Lite single word transfers, one slave
// Notes:   Store model answers save requests
`timescale 1ns/1ps
`include "pls_params.svh"

module pls_top_tb;
  import pls_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, pos_act = 32'h0, cur_act = 32'h7, trq_act = 32'h9;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, nv_zero_valid, nv_done, nv_wr, power_en, brake_engage;
  logic quick_stop, prof_decel;
  logic [31:0] hrdata, pos_cmd, trq_cmd, q;
  logic [18:0] nv_zero, nv_zero_wdata, zero_pos;
  int n_errors = 0, total_checks = 0, cyc = 0;

  // ****************************************************
  // Design, store and clock
  // ****************************************************
  pls_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pos_act(pos_act), .cur_act(cur_act), .trq_act(trq_act),
    .nv_zero(nv_zero), .nv_zero_valid(nv_zero_valid), .nv_done(nv_done), .nv_wr(nv_wr),
    .nv_zero_wdata(nv_zero_wdata), .pos_cmd(pos_cmd), .trq_cmd(trq_cmd), .power_en(power_en),
    .brake_engage(brake_engage), .quick_stop(quick_stop), .prof_decel(prof_decel),
    .zero_pos(zero_pos));
  pls_store_model u_store (.hclk(hclk), .nv_wr(nv_wr), .nv_zero_wdata(nv_zero_wdata),
    .nv_zero(nv_zero), .nv_zero_valid(nv_zero_valid), .nv_done(nv_done));
  always #20 hclk = ~hclk;

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer, held until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // Mode, position and both targets, then let outputs settle
  task automatic sup(input logic [7:0] m, input logic [31:0] p, tp, tt);
    pos_act <= p;
    wr(`PLS_OFF_MODE, {24'h0, m});
    wr(`PLS_OFF_TGT_POS, tp);
    wr(`PLS_OFF_TGT_TRQ, tt);
    repeat (3) @(posedge hclk);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_defaults();
    rc(`PLS_OFF_LIM_LO, `PLS_LIM_LO_RST);
    rc(`PLS_OFF_LIM_HI, `PLS_LIM_HI_RST);
    rc(`PLS_OFF_ZERO_ACT, 32'h40000);
    rc(`PLS_OFF_SAVE, 32'h0);
    $display("t_defaults done");
  endtask

  task automatic t_zero_save();
    int i;
    wr(`PLS_OFF_ZERO_CAL, 32'h0);
    rc(`PLS_OFF_ZERO_CAL, 32'h0);
    wr(`PLS_OFF_ZERO_CAL, 32'h7FFFF);
    wr(`PLS_OFF_ZERO_CAL, 32'h80000);
    rc(`PLS_OFF_ZERO_CAL, 32'h7FFFF);
    wr(`PLS_OFF_SAVE, 32'h65766174);
    rc(`PLS_OFF_SAVE, 32'h0);
    wr(`PLS_OFF_SAVE, `PLS_SAVE_KEY);
    rc(`PLS_OFF_SAVE, 32'h1);
    for (i = 0; i < 40 && q !== 32'h2; i++)
    begin
      repeat (100) @(posedge hclk);
      bus(1'b0, `PLS_OFF_SAVE, 32'h0);
    end
    chk(q, 32'h2);
    chk(nv_zero_wdata, 32'h7FFFF);
    chk(zero_pos, 32'h40000);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(zero_pos, 32'h7FFFF);
    $display("t_zero_save done");
  endtask

  task automatic t_modes();
    wr(`PLS_OFF_LIM_LO, 32'd100);
    wr(`PLS_OFF_LIM_HI, 32'd200);
    rc(`PLS_OFF_LIM_LO, 32'd100);
    rc(`PLS_OFF_LIM_HI, 32'd200);
    chk({31'h0, hresp}, 32'h0);
    sup(`PLS_MODE_PP, 32'd150, 32'd500, 32'd0);
    chk({pos_cmd[30:0], prof_decel}, {31'd200, 1'b1});
    sup(`PLS_MODE_PP, 32'd150, 32'd150, 32'd0);
    chk(pos_cmd, 32'd150);
    sup(`PLS_MODE_PT, 32'd250, 32'd0, 32'd5);
    chk({power_en, brake_engage, trq_cmd[29:0]}, 32'h0);
    rc(`PLS_OFF_CUR_RPT, 32'h0);
    rc(`PLS_OFF_TRQ_RPT, 32'h0);
    rc(`PLS_OFF_STATUS, 32'h6);
    sup(`PLS_MODE_PT, 32'd250, 32'd0, -32'sd5);
    chk({power_en, trq_cmd[30:0]}, {1'b1, 31'h7FFFFFFB});
    sup(`PLS_MODE_CSP, 32'd200, 32'd300, 32'd0);
    chk({quick_stop, pos_cmd[30:0]}, {1'b1, 31'd200});
    rc(`PLS_OFF_STATUS, 32'hA);
    sup(`PLS_MODE_CSP, 32'd200, 32'd150, 32'd0);
    chk(pos_cmd, 32'd150);
    sup(`PLS_MODE_CST, 32'd100, 32'd0, -32'sd5);
    chk({power_en, trq_cmd[30:0]}, 32'h0);
    rc(`PLS_OFF_CUR_RPT, 32'h0);
    rc(`PLS_OFF_TRQ_RPT, 32'h0);
    sup(`PLS_MODE_CST, 32'd100, 32'd0, 32'd5);
    chk({power_en, trq_cmd[30:0]}, {1'b1, 31'd5});
    sup(`PLS_MODE_CST, 32'd150, 32'd0, -32'sd5);
    chk({power_en, trq_cmd[30:0]}, {1'b1, 31'h7FFFFFFB});
    rc(`PLS_OFF_CUR_RPT, 32'h7);
    $display("t_modes done");
  endtask

  // ****************************************************
  // Sequence and timeout
  // ****************************************************
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(zero_pos, 32'h40000);
    t_defaults();
    t_zero_save();
    t_modes();
    wrap_up();
  end
endmodule // pls_top_tb
